// ---- osw_regs.vh ----
// Register map, field positions and timing constants of the octal output switch control block
//
// Functional notes
// [RL1] With crc_check_enable_pin high every serial frame carries a checked CRC byte.
// [RL2] Checked frames are command, data and CRC; otherwise command and data only.
// [RL3] Open-drain fault pin pulled low while an enabled fault flag stands.
// [RL4] Rising strobe edge copies the stored output state onto all outputs together.
// [RL5] With the strobe held high a state write reaches the outputs at once.
// [RL6] Sixteen LEDs on a 4x4 scanned matrix show on state and fault per channel.
// [RL7] Lamp load at turn-on suppresses that channel's warnings for 200 ms.
// [RL8] Lamp detection sets no flag and raises no fault.
// [RL9] Overcurrent on a channel sets its bit in the overcurrent flag register.
// [RL10] Overcurrent fault mask resets to one, so overcurrent drives the fault pin.
// [RL11] Mask bit zero keeps overcurrent off the fault pin; flags still record.
// [RL12] Thermal overload sets its flag and asserts fault regardless of the mask.
// [RL13] Fault holds until the condition is gone and the host clears the flags.
// [RL14] With the strobe low a state write only stores the pending state.
`ifndef OSW_REGS_VH
`define OSW_REGS_VH
`define OSW_A_OUT 4'h0
`define OSW_A_OCF 4'h1
`define OSW_A_THF 4'h2
`define OSW_A_CFG 4'h3
`define OSW_A_OCCLR 4'h4
`define OSW_A_THCLR 4'h5
`define OSW_A_IST 4'h6
`define OSW_A_ICLR 4'h7
`define OSW_A_IEN 4'h8
`define OSW_A_OUTNOW 4'h9
`define OSW_CFG_RST 8'h01
`define OSW_CFG_OCMASK 0
`define OSW_IRQ_OC 0
`define OSW_IRQ_TH 1
`define OSW_IRQ_CRC 2
`define OSW_IRQ_FRM 3
`define OSW_CRC_POLY 8'h07
`define OSW_WR_BIT 7
`define OSW_FRM_BITS 5'h10
`define OSW_FRM_BITS_CRC 5'h18
`define OSW_CLK_MHZ 40
`define OSW_LAMP_MS 200
`define OSW_LAMP_CYC (`OSW_LAMP_MS * 1000 * `OSW_CLK_MHZ)
`define OSW_SCAN_US 100
`define OSW_SCAN_CYC (`OSW_SCAN_US * `OSW_CLK_MHZ)
`endif

// ---- osw_ctrl.v ----
// Octal high-side output control: serial link, output update, fault flags, LED matrix
//
// Local design decisions: the plain strobed port and the register addresses.
`include "osw_regs.vh"
`default_nettype none
module osw_ctrl #(
  parameter integer LAMP_CYC = `OSW_LAMP_CYC
) (
  input wire sys_clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  input wire crc_check_enable_pin,
  input wire output_update_strobe,
  input wire [7:0] oc_detect,
  input wire [7:0] th_detect,
  input wire [7:0] lamp_detect,
  output reg [7:0] hs_out,
  output reg fault_n_o,
  output reg fault_n_oe,
  output reg [3:0] led_row,
  output reg [3:0] led_col,
  output reg irq
);

  localparam integer SCAN_FULL = `OSW_SCAN_CYC;
  // Scan period and lamp window fit their counters; cut to width on purpose
  localparam [11:0] SCAN_CYC = SCAN_FULL[11:0];
  localparam [22:0] LAMP_LOAD = LAMP_CYC[22:0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds only stage two
  reg [28:0] sync1_r;
  reg [28:0] sync2_r;
  reg [2:0] edge_d_r;
  wire s_sclk = sync2_r[28];
  wire s_csn = sync2_r[27];
  wire s_mosi = sync2_r[26];
  wire s_crc_check_enable_pin = sync2_r[25];
  wire s_strobe = sync2_r[24];
  wire [7:0] s_oc = sync2_r[23:16];
  wire [7:0] s_th = sync2_r[15:8];
  wire [7:0] s_lamp = sync2_r[7:0];

  always @(posedge sys_clk) begin
    if (reset) begin
      // Idle levels: link clock low, select high, so no false edge follows reset
      sync1_r <= 29'h08000000;
      sync2_r <= 29'h08000000;
      edge_d_r <= 3'h2;
    end else begin
      sync1_r <= {spi_sclk, spi_cs_n, spi_mosi, crc_check_enable_pin, output_update_strobe,
                  oc_detect, th_detect, lamp_detect};
      sync2_r <= sync1_r;
      edge_d_r <= {s_sclk, s_csn, s_strobe};
    end
  end

  wire sclk_rise = s_sclk & ~edge_d_r[2];
  wire sclk_fall = ~s_sclk & edge_d_r[2];
  wire cs_start = edge_d_r[1] & ~s_csn;
  wire cs_end = ~edge_d_r[1] & s_csn;
  wire strobe_rise = s_strobe & ~edge_d_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] out_state_r;
  reg [7:0] ocf_r;
  reg [7:0] thf_r;
  reg [7:0] cfg_r;
  reg [3:0] ist_r;
  reg [3:0] ien_r;
  reg spi_pend_r;
  reg [3:0] spi_addr_r;
  reg [7:0] spi_data_r;

  // Host port wins a same-cycle collision; the serial write waits until reg_wr drops
  wire wr_en = reg_wr | spi_pend_r;
  wire [3:0] wr_addr = reg_wr ? reg_addr : spi_addr_r;
  wire [7:0] wr_data = reg_wr ? reg_wdata : spi_data_r;

  function [7:0] rd_val;
    input [3:0] a;
    begin
      case (a)
        `OSW_A_OUT: rd_val = out_state_r;
        `OSW_A_OCF: rd_val = ocf_r;
        `OSW_A_THF: rd_val = thf_r;
        `OSW_A_CFG: rd_val = cfg_r;
        `OSW_A_IST: rd_val = {4'h0, ist_r};
        `OSW_A_IEN: rd_val = {4'h0, ien_r};
        `OSW_A_OUTNOW: rd_val = hs_out;
        default: rd_val = 8'h00;
      endcase
    end
  endfunction

  function [7:0] crc_step;
    input [7:0] c;
    input b;
    begin
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `OSW_CRC_POLY : 8'h00);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial link, mode 0, sampled on the system clock
  reg [4:0] bit_cnt_r;
  reg [23:0] in_sh_r;
  reg [7:0] out_sh_r;
  reg [7:0] cmd_r;
  reg [7:0] crc_in_r;
  reg [7:0] crc_out_r;
  reg ev_crc_r;
  reg ev_frm_r;

  wire [4:0] frm_len = s_crc_check_enable_pin ? `OSW_FRM_BITS_CRC : `OSW_FRM_BITS; // RL2
  wire crc_ok = ~s_crc_check_enable_pin | (in_sh_r[7:0] == crc_in_r); // RL1
  wire frm_ok = (bit_cnt_r == frm_len) & crc_ok;

  always @(posedge sys_clk) begin
    if (reset) begin
      bit_cnt_r <= 5'h00;
      in_sh_r <= 24'h000000;
      out_sh_r <= 8'h00;
      cmd_r <= 8'h00;
      crc_in_r <= 8'h00;
      crc_out_r <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      ev_crc_r <= 1'b0;
      ev_frm_r <= 1'b0;
      spi_pend_r <= 1'b0;
      spi_addr_r <= 4'h0;
      spi_data_r <= 8'h00;
    end else begin
      ev_crc_r <= 1'b0;
      ev_frm_r <= 1'b0;
      if (!reg_wr) begin
        spi_pend_r <= 1'b0;
      end
      if (cs_start) begin
        // First byte out is the per-channel fault summary
        bit_cnt_r <= 5'h00;
        crc_in_r <= 8'h00;
        crc_out_r <= 8'h00;
        spi_miso_oe <= 1'b1;
        spi_miso <= ocf_r[7] | thf_r[7];
        out_sh_r <= {ocf_r[6:0] | thf_r[6:0], 1'b0};
      end else if (cs_end) begin
        spi_miso_oe <= 1'b0;
        ev_frm_r <= frm_ok;
        ev_crc_r <= ~frm_ok; // RL1
        if (frm_ok && cmd_r[`OSW_WR_BIT]) begin
          spi_pend_r <= 1'b1;
          spi_addr_r <= cmd_r[3:0];
          spi_data_r <= s_crc_check_enable_pin ? in_sh_r[15:8] : in_sh_r[7:0];
        end
      end else if (!s_csn && sclk_rise) begin
        in_sh_r <= {in_sh_r[22:0], s_mosi};
        if (bit_cnt_r != 5'h1F) begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        if (bit_cnt_r < `OSW_FRM_BITS) begin
          crc_in_r <= crc_step(crc_in_r, s_mosi);
          crc_out_r <= crc_step(crc_out_r, spi_miso);
        end
        if (bit_cnt_r == 5'h07) begin
          cmd_r <= {in_sh_r[6:0], s_mosi};
        end
      end else if (!s_csn && sclk_fall) begin
        if (bit_cnt_r == 5'h08) begin
          {spi_miso, out_sh_r} <= {rd_val(cmd_r[3:0]), 1'b0};
        end else if (bit_cnt_r == `OSW_FRM_BITS) begin
          spi_miso <= crc_out_r[7]; // RL1
          out_sh_r <= {crc_out_r[6:0], 1'b0};
        end else begin
          spi_miso <= out_sh_r[7];
          out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp-load blanking per channel
  wire [7:0] lamp_sup;
  reg [7:0] lamp_d_r;
  wire [7:0] lamp_rise = s_lamp & ~lamp_d_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      lamp_d_r <= 8'h00;
    end else begin
      lamp_d_r <= s_lamp;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lamp
      reg [22:0] cnt_r;
      always @(posedge sys_clk) begin
        if (reset) begin
          cnt_r <= 23'h000000;
        end else if (lamp_rise[g] && hs_out[g]) begin
          cnt_r <= LAMP_LOAD; // RL7
        end else if (cnt_r != 23'h000000) begin
          cnt_r <= cnt_r - 23'h000001;
        end
      end
      assign lamp_sup[g] = (cnt_r != 23'h000000);
    end
  endgenerate

  // Blanking only hides events; nothing records the lamp itself
  wire [7:0] oc_ev = s_oc & ~lamp_sup; // RL7 RL8
  wire [7:0] th_ev = s_th & ~lamp_sup; // RL7 RL8

  ////////////////////////////////////////////////////////////////////////////
  // Registers, flags, outputs, interrupt
  wire wr_out = wr_en && (wr_addr == `OSW_A_OUT);
  wire [7:0] occlr = (wr_en && wr_addr == `OSW_A_OCCLR) ? wr_data : 8'h00;
  wire [7:0] thclr = (wr_en && wr_addr == `OSW_A_THCLR) ? wr_data : 8'h00;
  wire [3:0] iclr = (wr_en && wr_addr == `OSW_A_ICLR) ? wr_data[3:0] : 4'h0;
  wire [3:0] ev = {ev_frm_r, ev_crc_r, |th_ev, |oc_ev};
  wire [3:0] ist_nxt = (ist_r & ~iclr) | ev;
  wire [7:0] ocf_nxt = (ocf_r & ~occlr) | oc_ev; // RL9 RL13
  wire [7:0] thf_nxt = (thf_r & ~thclr) | th_ev; // RL12 RL13

  always @(posedge sys_clk) begin
    if (reset) begin
      out_state_r <= 8'h00;
      hs_out <= 8'h00;
      ocf_r <= 8'h00;
      thf_r <= 8'h00;
      cfg_r <= `OSW_CFG_RST; // RL10
      ist_r <= 4'h0;
      ien_r <= 4'h0;
      irq <= 1'b0;
      fault_n_o <= 1'b0;
      fault_n_oe <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_out) begin
        out_state_r <= wr_data; // RL14
      end
      if (wr_out && s_strobe) begin
        hs_out <= wr_data; // RL5
      end else if (strobe_rise) begin
        hs_out <= out_state_r; // RL4
      end
      if (wr_en && wr_addr == `OSW_A_CFG) begin
        cfg_r <= wr_data;
      end
      if (wr_en && wr_addr == `OSW_A_IEN) begin
        ien_r <= wr_data[3:0];
      end
      ocf_r <= ocf_nxt;
      thf_r <= thf_nxt;
      ist_r <= ist_nxt;
      irq <= |(ist_nxt & ien_r);
      // Pin released when no enabled flag stands; flags clear only once the cause is gone
      fault_n_oe <= (|ocf_nxt & cfg_r[`OSW_CFG_OCMASK]) | (|thf_nxt); // RL3 RL11 RL12 RL13
      if (reg_rd) begin
        reg_rdata <= rd_val(reg_addr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED matrix: rows 0-1 on state, rows 2-3 fault per channel
  reg [11:0] scan_cnt_r;
  reg [1:0] row_r;
  wire [15:0] led_map = {ocf_r | thf_r, hs_out};

  always @(posedge sys_clk) begin
    if (reset) begin
      scan_cnt_r <= 12'h000;
      row_r <= 2'h0;
      led_row <= 4'h0;
      led_col <= 4'h0;
    end else begin
      if (scan_cnt_r == SCAN_CYC - 12'h001) begin
        scan_cnt_r <= 12'h000;
        row_r <= row_r + 2'h1;
      end else begin
        scan_cnt_r <= scan_cnt_r + 12'h001;
      end
      led_row <= 4'h1 << row_r; // RL6
      led_col <= led_map[row_r * 4 +: 4]; // RL6
    end
  end

endmodule
`default_nettype wire

// ---- osw_ctrl_note_end.v ----
`default_nettype none
`default_nettype wire

// ---- osw_ctrl_chk.sv ----
// Port-level assertions for the output switch control block
`default_nettype none
module osw_ctrl_chk #(parameter integer LAMP_CYC = 50) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic output_update_strobe,
  input wire logic [7:0] th_detect,
  input wire logic [7:0] lamp_detect,
  input wire logic [7:0] hs_out,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic [3:0] led_row,
  input wire logic [3:0] led_col
);
  timeunit 1ns;
  timeprecision 1ps;
  int quiet_r = 0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Blanking outlives the lamp input
  always @(posedge sys_clk) quiet_r <= (reset || lamp_detect != 8'h00) ? 0 : quiet_r + 1;
  sequence low_s; !output_update_strobe [*5]; endsequence
  sequence live_s; output_update_strobe [*4] ##0 (reg_wr && reg_addr == 4'h0); endsequence
  sequence th_s; (th_detect != 8'h00 && quiet_r > LAMP_CYC + 8) [*7]; endsequence
  fault_pull_a: assert property (fault_n_oe |-> !fault_n_o) else $error("fault pin high");
  hold_state_a: assert property (low_s |=> $stable(hs_out)) else $error("outputs moved");
  live_write_a: assert property (live_s |=> hs_out == $past(reg_wdata)) else $error("live write lost");
  therm_fault_a: assert property (th_s |-> fault_n_oe) else $error("no overload fault");
  fault_hold_a: assert property ($fell(fault_n_oe) |-> th_detect == 8'h00 && $past(th_detect, 3) == 8'h00)
    else $error("fault released early");
  led_onehot_a: assert property ($onehot0(led_row)) else $error("rows overlap");
  led_dwell_a: assert property ($changed(led_row) |=> $stable(led_row) [*8]) else $error("row too short");
  led_col_a: assert property (led_row == 4'h1 && $stable(hs_out) && $stable(led_row) |-> led_col == hs_out[3:0])
    else $error("row data wrong");
endmodule
bind osw_ctrl osw_ctrl_chk #(.LAMP_CYC(LAMP_CYC)) osw_ctrl_chk_inst (.sys_clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .output_update_strobe, .th_detect, .lamp_detect, .hs_out, .fault_n_o, .fault_n_oe, .led_row, .led_col);
`default_nettype wire

// ---- osw_host.sv ----
// Host model of the serial link: mode 0 frames with optional CRC byte
`default_nettype none
module osw_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] reply_r = 24'h000000;
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, input logic crc_on, input logic bad);
    logic [23:0] frm;
    frm = {cmd, dat, crc8({cmd, dat}) ^ {7'h00, bad}};
    // Keep link edges off the system clock edges
    #5;
    spi_cs_n = 1'b0;
    #200;
    for (int i = 0; i < (crc_on ? 24 : 16); i++) begin
      spi_mosi = frm[23 - i];
      #100 spi_sclk = 1'b1;
      // Reply taken late in the high phase, after the slow resync
      #99 reply_r = {reply_r[22:0], spi_miso};
      #1 spi_sclk = 1'b0;
    end
    #100 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #200;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the output switch control block
`default_nettype none
`include "osw_regs.vh"
`define CHK(nm, ex, got) begin n_compared++; \
  if ((got) !== (ex)) begin fail_count++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAMP = 50;
  logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic output_update_strobe = 1'b0, crc_check_enable_pin = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, oc_detect = 8'h00, th_detect = 8'h00, lamp_detect = 8'h00, reg_rdata, hs_out;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, fault_n_o, fault_n_oe, irq;
  logic [3:0] led_row, led_col;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  osw_ctrl #(.LAMP_CYC(LAMP)) osw_ctrl_inst (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .crc_check_enable_pin, .output_update_strobe,
    .oc_detect, .th_detect, .lamp_detect, .hs_out, .fault_n_o, .fault_n_oe, .led_row, .led_col, .irq);
  osw_host osw_host_inst (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK("rdata", ex, reg_rdata)
  endtask
  ////////////////////////////////////////
  task automatic t_strobe;
    wr(`OSW_A_OUT, 8'hA5);
    tick(4);
    `CHK("pending", 8'h00, hs_out)
    @(posedge sys_clk) output_update_strobe <= 1'b1;
    tick(6);
    `CHK("synced", 8'hA5, hs_out)
    wr(`OSW_A_OUT, 8'h3C);
    #1 `CHK("live", 8'h3C, hs_out)
  endtask
  task automatic t_oc;
    wr(`OSW_A_IEN, 8'h01);
    @(posedge sys_clk) oc_detect <= 8'h81;
    tick(8);
    `CHK("oc fault", 1'b1, fault_n_oe)
    `CHK("irq", 1'b1, irq)
    rd(`OSW_A_OCF, 8'h81);
    wr(`OSW_A_OCCLR, 8'h81);
    rd(`OSW_A_OCF, 8'h81);
    wr(`OSW_A_IEN, 8'h00);
    tick(2);
    `CHK("irq off", 1'b0, irq)
    @(posedge sys_clk) oc_detect <= 8'h00;
    tick(6);
    wr(`OSW_A_OCCLR, 8'h81);
    wr(`OSW_A_ICLR, 8'h0F);
    wr(`OSW_A_IEN, 8'h01);
    tick(2);
    `CHK("cleared", 1'b0, fault_n_oe)
    `CHK("irq clr", 1'b0, irq)
    wr(`OSW_A_CFG, 8'h00);
    @(posedge sys_clk) oc_detect <= 8'h10;
    tick(8);
    `CHK("masked", 1'b0, fault_n_oe)
    rd(`OSW_A_OCF, 8'h10);
    @(posedge sys_clk) oc_detect <= 8'h00;
    tick(6);
    wr(`OSW_A_OCCLR, 8'h10);
  endtask
  task automatic t_th;
    @(posedge sys_clk) th_detect <= 8'h02;
    tick(8);
    `CHK("th fault", 1'b1, fault_n_oe)
    rd(`OSW_A_THF, 8'h02);
    @(posedge sys_clk) th_detect <= 8'h00;
    tick(6);
    wr(`OSW_A_THCLR, 8'h02);
    wr(`OSW_A_CFG, 8'h01);
    wr(`OSW_A_ICLR, 8'h0F);
    tick(2);
    `CHK("th clr", 1'b0, fault_n_oe)
  endtask
  task automatic t_lamp;
    @(posedge sys_clk) lamp_detect <= 8'h04;
    tick(3);
    @(posedge sys_clk) oc_detect <= 8'h04;
    tick(LAMP / 2);
    `CHK("blanked", 1'b0, fault_n_oe)
    rd(`OSW_A_IST, 8'h00);
    @(posedge sys_clk) lamp_detect <= 8'h00;
    tick(LAMP + 10);
    `CHK("unblanked", 1'b1, fault_n_oe)
    @(posedge sys_clk) oc_detect <= 8'h00;
    tick(6);
    wr(`OSW_A_OCCLR, 8'h04);
    wr(`OSW_A_ICLR, 8'h0F);
  endtask
  task automatic t_spi;
    fork
      osw_host_inst.xfer(8'h80, 8'h5A, 1'b0, 1'b0);
      begin
        tick(20);
        `CHK("miso oe", 1'b1, spi_miso_oe)
      end
    join
    `CHK("miso off", 1'b0, spi_miso_oe)
    tick(8);
    `CHK("spi out", 8'h5A, hs_out)
    `CHK("reply", 16'h003C, osw_host_inst.reply_r[15:0])
    @(posedge sys_clk) crc_check_enable_pin <= 1'b1;
    tick(4);
    osw_host_inst.xfer(8'h80, 8'h11, 1'b1, 1'b0);
    tick(8);
    `CHK("crc out", 8'h11, hs_out)
    `CHK("crc", osw_host_inst.crc8(osw_host_inst.reply_r[23:8]), osw_host_inst.reply_r[7:0])
    osw_host_inst.xfer(8'h80, 8'h22, 1'b1, 1'b1);
    tick(8);
    `CHK("bad crc", 8'h11, hs_out)
    rd(`OSW_A_IST, 8'h0C);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(`OSW_A_CFG, `OSW_CFG_RST);
    rd(4'hF, 8'h00);
    t_strobe();
    t_oc();
    t_th();
    t_lamp();
    t_spi();
    // Long idle lets the LED scan step
    tick(9000);
    final_report();
  end
endmodule
`default_nettype wire
